/* File: dv/evr_router_monitor.sv */
// Bus handshake checks for the event router.
// Bound to evr_router; sees its ports only.
`timescale 1ns/100ps
`include "evr_consts.svh"

module evr_router_monitor
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_irq,
  input wire logic        o_wakeup
);
  default clocking mcb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  bresp_hold_a: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped early");
  bresp_done_a: assert property (
    o_bvalid && i_bready |=> !o_bvalid)
    else $error("write answer repeated");
  rdata_done_a: assert property (
    o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer repeated");
  read_answer_a: assert property (
    i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  read_block_a: assert property (
    o_rvalid |-> !o_arready)
    else $error("read taken while answer pending");
  write_block_a: assert property (
    o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answer pending");
  bresp_code_a: assert property (
    o_bvalid |-> o_bresp == `EVR_RESP_OKAY
                 || o_bresp == `EVR_RESP_SLVERR)
    else $error("bad write response code");
  err_zero_a: assert property (
    o_rvalid && o_rresp == `EVR_RESP_SLVERR |-> o_rdata == 32'h0)
    else $error("refused read returns data");

  wake_c: cover property ($rose(o_wakeup));
  irq_c: cover property ($rose(o_irq));
  err_c: cover property (o_bvalid && o_bresp == `EVR_RESP_SLVERR);
endmodule : evr_router_monitor

bind evr_router evr_router_monitor mon
(
  .i_core_clk (i_core_clk),
  .i_rst_n    (i_rst_n),
  .o_awready  (o_awready),
  .o_wready   (o_wready),
  .o_bvalid   (o_bvalid),
  .i_bready   (i_bready),
  .o_bresp    (o_bresp),
  .i_arvalid  (i_arvalid),
  .o_arready  (o_arready),
  .o_rvalid   (o_rvalid),
  .i_rready   (i_rready),
  .o_rdata    (o_rdata),
  .o_rresp    (o_rresp),
  .o_irq      (o_irq),
  .o_wakeup   (o_wakeup)
);

/* File: dv/evr_sink_model.sv */
// Stand-in for interrupt controller and clock generation unit.
// Watches the router wakeup and irq outputs on the core clock.
`timescale 1ns/100ps
`include "evr_consts.svh"

module evr_sink_model
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`EVR_N_IRQ-1:0] i_event_int,
  input  wire logic                  i_wakeup,
  input  wire logic                  i_irq,
  output logic                       o_woken,
  output logic [7:0]                 o_irq_seen
);
  logic irq_last;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_woken <= 1'b0;
    else if (i_wakeup)
      o_woken <= 1'b1;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      irq_last   <= 1'b0;
      o_irq_seen <= 8'h00;
    end
    else
    begin
      irq_last <= i_irq;
      if (i_irq && !irq_last)
        o_irq_seen <= o_irq_seen + 8'h01;
    end
endmodule : evr_sink_model

/* File: dv/tb.sv */
// Self-checking bench for the event router.
// Drives AXI4-Lite and event inputs; sink model on the outputs.
`timescale 1ns/100ps
`include "evr_consts.svh"

module tb;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_evt_internal = 8'h00;
  logic [23:0] i_evt_pin = 24'hffffff;
  logic        i_awvalid = 1'b0;
  logic        i_wvalid = 1'b0;
  logic        i_bready = 1'b0;
  logic        i_arvalid = 1'b0;
  logic        i_rready = 1'b0;
  logic [7:0]  i_awaddr = 8'h00;
  logic [7:0]  i_araddr = 8'h00;
  logic [2:0]  i_awprot = 3'h0;
  logic [2:0]  i_arprot = 3'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'hf;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_wakeup, o_irq, woken;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [3:0]  o_event_int;
  logic [7:0]  irq_seen;
  int          err_count = 0;
  int          checks_done = 0;

  evr_router uut (.*);
  evr_sink_model sink (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_event_int(o_event_int), .i_wakeup(o_wakeup), .i_irq(o_irq),
    .o_woken(woken), .o_irq_seen(irq_seen));

  always #12.5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit done;
    done = 1'b0;
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    for (int k = 0; k < 20 && !done; k++)
    begin
      @(posedge i_core_clk);
      if (o_awready)
        i_awvalid <= 1'b0;
      if (o_wready)
        i_wvalid <= 1'b0;
      if (o_bvalid)
      begin
        chk(o_bresp, er);
        i_bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(done, 1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    bit done;
    done = 1'b0;
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    for (int k = 0; k < 20 && !done; k++)
    begin
      @(posedge i_core_clk);
      if (o_arready)
        i_arvalid <= 1'b0;
      if (o_rvalid)
      begin
        chk(o_rdata, ed);
        chk(o_rresp, er);
        i_rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(done, 1);
  endtask : rd

  task automatic t_reset();
    rd(`EVR_OFF_POLARITY, `EVR_RST_POLARITY, `EVR_RESP_OKAY);
    rd(`EVR_OFF_MODE, `EVR_RST_MODE, `EVR_RESP_OKAY);
    rd(`EVR_OFF_GMASK, `EVR_RST_GMASK, `EVR_RESP_OKAY);
    rd(`EVR_OFF_IRQMASK, 32'h0, `EVR_RESP_OKAY);
    rd(8'h80, 32'h0, `EVR_RESP_SLVERR);
    wr(8'h80, 32'h1, `EVR_RESP_SLVERR);
  endtask : t_reset

  task automatic t_direct();
    wr(`EVR_OFF_GMASK, 32'hfffffffe, `EVR_RESP_OKAY);
    wr(`EVR_OFF_ENABLE0, 32'h1, `EVR_RESP_OKAY);
    wr(8'h24, 32'h1, `EVR_RESP_OKAY);
    i_evt_internal <= 8'h01;
    cyc(2);
    chk({o_wakeup, o_event_int}, 32'h11);
    chk(o_irq, 0);
    rd(`EVR_OFF_STATUS0, 32'h1, `EVR_RESP_OKAY);
    rd(8'h2c, 32'h0, `EVR_RESP_OKAY);
    chk(woken, 1);
    i_evt_internal <= 8'h00;
    cyc(2);
    chk({o_wakeup, o_event_int}, 32'h0);
    wr(`EVR_OFF_GMASK, 32'hffffffff, `EVR_RESP_OKAY);
    i_evt_internal <= 8'h01;
    cyc(2);
    chk({o_wakeup, o_event_int}, 32'h0);
    i_evt_internal <= 8'h00;
  endtask : t_direct

  task automatic t_latched();
    rd(`EVR_OFF_IRQSTAT, 32'h11, `EVR_RESP_OKAY);
    wr(`EVR_OFF_IRQMASK, 32'h2, `EVR_RESP_OKAY);
    wr(`EVR_OFF_POLARITY, 32'hfffffeff, `EVR_RESP_OKAY);
    wr(`EVR_OFF_MODE, 32'h100, `EVR_RESP_OKAY);
    wr(`EVR_OFF_GMASK, 32'hfffffeff, `EVR_RESP_OKAY);
    wr(8'h18, 32'h100, `EVR_RESP_OKAY);
    cyc(2);
    chk(o_event_int, 0);
    i_evt_pin <= 24'hfffffe;
    @(posedge i_core_clk);
    i_evt_pin <= 24'hffffff;
    cyc(3);
    chk(o_event_int, 32'h2);
    chk(o_irq, 1);
    rd(`EVR_OFF_PRESENT, 32'hffffff00, `EVR_RESP_OKAY);
    rd(`EVR_OFF_IRQSTAT, 32'h2, `EVR_RESP_OKAY);
    cyc(2);
    chk(o_irq, 0);
    wr(`EVR_OFF_CLEAR, 32'h0, `EVR_RESP_OKAY);
    cyc(2);
    chk(o_event_int, 32'h2);
    wr(`EVR_OFF_CLEAR, 32'h100, `EVR_RESP_OKAY);
    cyc(2);
    chk(o_event_int, 0);
    chk(irq_seen, 1);
  endtask : t_latched

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_direct();
    t_latched();
    stop_test();
  end

  initial
  begin
    #50000;
    err_count++;
    stop_test();
  end
endmodule : tb

/* File: logic/evr_consts.svh */
// Named offsets, reset values and sizes of the event router.
// Assumes a 32-bit AXI4-Lite bus with byte addresses in 8 bits.
`ifndef EVR_CONSTS_SVH
`define EVR_CONSTS_SVH

`define EVR_N_INT        8
`define EVR_N_PIN        24
`define EVR_N_IN         32
`define EVR_N_IRQ        4
`define EVR_N_OUT        5
`define EVR_WAKE_IDX     4
`define EVR_ADDR_W       8

`define EVR_OFF_POLARITY 8'h00
`define EVR_OFF_MODE     8'h04
`define EVR_OFF_GMASK    8'h08
`define EVR_OFF_CLEAR    8'h0c
`define EVR_OFF_PRESENT  8'h10
`define EVR_OFF_ENABLE0  8'h14
`define EVR_OFF_STATUS0  8'h28
`define EVR_OFF_IRQSTAT  8'h3c
`define EVR_OFF_IRQMASK  8'h40
`define EVR_OFF_STRIDE   8'h04

`define EVR_RST_POLARITY 32'hffffffff
`define EVR_RST_MODE     32'h00000000
`define EVR_RST_GMASK    32'hffffffff
`define EVR_RST_ENABLE   32'h00000000
`define EVR_RST_IRQMASK  5'h00

`define EVR_RESP_OKAY    2'h0
`define EVR_RESP_SLVERR  2'h2

`endif

/* File: logic/evr_detect.sv */
// Per-input event qualification: polarity, direct or latched capture.
// Assumes inputs synchronous to i_core_clk; clear is a one-cycle pulse.
`timescale 1ns/100ps
`include "evr_consts.svh"

module evr_detect
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire evr_pkg::evr_vec_t i_raw,
  input  wire evr_pkg::evr_vec_t i_polarity,
  input  wire evr_pkg::evr_vec_t i_latched,
  input  wire evr_pkg::evr_vec_t i_clear,
  output evr_pkg::evr_vec_t      o_present
);

  evr_pkg::evr_vec_t active;
  evr_pkg::evr_vec_t active_d;
  evr_pkg::evr_vec_t latch;
  evr_pkg::evr_vec_t next_latch;
  evr_pkg::evr_vec_t edge_seen;

  assign active     = ~(i_raw ^ i_polarity);
  assign edge_seen  = active & ~active_d;
  // one clears, set wins
  // Direct inputs keep no stale latch
  assign next_latch = ((latch & ~i_clear) | edge_seen) & i_latched;
  assign o_present  = (i_latched & latch) | (~i_latched & active);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      active_d <= '0;
      latch    <= '0;
    end
    else
    begin
      active_d <= active;
      latch    <= next_latch;
    end
  end

endmodule : evr_detect

/* File: logic/evr_pkg.sv */
// Types shared by the event router files.
// Assumes evr_consts.svh for the vector and address widths; evr_word_t is a fixed 32 bits.
`include "evr_consts.svh"

package evr_pkg;
  typedef logic [31:0]               evr_word_t;
  typedef logic [`EVR_N_IN-1:0]      evr_vec_t;
  typedef logic [`EVR_ADDR_W-1:0]    evr_addr_t;
endpackage : evr_pkg

/* File: logic/evr_router.sv */
// Event router top: AXI4-Lite registers, detection, routing, interrupt.
// Assumes one 40 MHz clock; all event inputs synchronous to it.
`timescale 1ns/100ps
`include "evr_consts.svh"

module evr_router
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [`EVR_N_INT-1:0]  i_evt_internal,
  input  wire logic [`EVR_N_PIN-1:0]  i_evt_pin,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [`EVR_ADDR_W-1:0] i_awaddr,
  input  wire logic [2:0]             i_awprot,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output logic [1:0]                  o_bresp,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [`EVR_ADDR_W-1:0] i_araddr,
  input  wire logic [2:0]             i_arprot,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  output logic [`EVR_N_IRQ-1:0]       o_event_int,
  output logic                        o_wakeup,
  output logic                        o_irq
);

  // Register decode helpers
  function automatic logic off_is
  (
    input evr_pkg::evr_addr_t a,
    input evr_pkg::evr_addr_t off
  );
    off_is = (a[`EVR_ADDR_W-1:2] == off[`EVR_ADDR_W-1:2]);
  endfunction : off_is

  function automatic logic [2:0] out_idx
  (
    input evr_pkg::evr_addr_t a,
    input evr_pkg::evr_addr_t base
  );
    evr_pkg::evr_addr_t d;
    d       = a - base;
    out_idx = d[4:2];
  endfunction : out_idx

  function automatic logic in_bank
  (
    input evr_pkg::evr_addr_t a,
    input evr_pkg::evr_addr_t base
  );
    evr_pkg::evr_addr_t d;
    d       = a - base;
    in_bank = (a[`EVR_ADDR_W-1:2] >= base[`EVR_ADDR_W-1:2]) &&
              (d[`EVR_ADDR_W-1:2] < (`EVR_ADDR_W-2)'(`EVR_N_OUT));
  endfunction : in_bank

  function automatic evr_pkg::evr_word_t merge
  (
    input evr_pkg::evr_word_t old,
    input evr_pkg::evr_word_t nw,
    input logic [3:0]         strb
  );
    evr_pkg::evr_word_t m;
    m     = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Configuration and state
  evr_pkg::evr_vec_t              polarity;
  evr_pkg::evr_vec_t              mode;
  evr_pkg::evr_vec_t              gmask;
  evr_pkg::evr_vec_t              enable [`EVR_N_OUT];
  evr_pkg::evr_vec_t              clear_pulse;
  evr_pkg::evr_vec_t              raw;
  evr_pkg::evr_vec_t              present;
  evr_pkg::evr_vec_t              routed [`EVR_N_OUT];
  logic [`EVR_N_OUT-1:0]          out_now;
  logic [`EVR_N_OUT-1:0]          out_q;
  logic [`EVR_N_OUT-1:0]          irq_stat;
  logic [`EVR_N_OUT-1:0]          irq_mask;
  logic [`EVR_N_OUT-1:0]          next_irq_stat;
  logic [`EVR_N_OUT-1:0]          out_rise;

  // Bus state
  logic                           aw_got;
  logic                           w_got;
  evr_pkg::evr_addr_t             aw_addr;
  evr_pkg::evr_word_t             w_data;
  logic [3:0]                     w_strb;
  logic                           next_aw_got;
  logic                           next_w_got;
  logic                           next_bvalid;
  logic                           do_write;
  logic                           aw_take;
  logic                           w_take;
  logic                           ar_take;
  logic                           wr_hit;
  logic                           rd_hit;
  logic                           rd_irqstat;
  evr_pkg::evr_word_t             rd_word;
  logic [2:0]                     wr_en_idx;
  logic [2:0]                     rd_en_idx;
  logic [2:0]                     rd_st_idx;

  assign raw = {i_evt_pin, i_evt_internal};

  evr_detect u_detect
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_raw      (raw),
    .i_polarity (polarity),
    .i_latched  (mode),
    .i_clear    (clear_pulse),
    .o_present  (present)
  );

  genvar g;
  generate
    for (g = 0; g < `EVR_N_OUT; g++)
    begin : g_route
      assign routed[g]  = present & ~gmask & enable[g];
      assign out_now[g] = |routed[g];
    end
  endgenerate

  assign out_rise = out_now & ~out_q;

  // Write channel handshake
  assign aw_take     = i_awvalid & o_awready;
  assign w_take      = i_wvalid & o_wready;
  assign do_write    = aw_got & w_got & ~o_bvalid;
  assign next_aw_got = (aw_got | aw_take) & ~do_write;
  assign next_w_got  = (w_got | w_take) & ~do_write;
  assign next_bvalid = do_write | (o_bvalid & ~i_bready);

  // Write decode
  assign wr_en_idx = out_idx(aw_addr, `EVR_OFF_ENABLE0);
  assign wr_hit    = off_is(aw_addr, `EVR_OFF_POLARITY) |
                     off_is(aw_addr, `EVR_OFF_MODE) |
                     off_is(aw_addr, `EVR_OFF_GMASK) |
                     off_is(aw_addr, `EVR_OFF_CLEAR) |
                     off_is(aw_addr, `EVR_OFF_IRQMASK) |
                     in_bank(aw_addr, `EVR_OFF_ENABLE0);
  assign clear_pulse = (do_write && off_is(aw_addr, `EVR_OFF_CLEAR)) ?
                       merge('0, w_data, w_strb) : '0;

  // Read decode
  assign ar_take    = i_arvalid & o_arready;
  assign rd_en_idx  = out_idx(i_araddr, `EVR_OFF_ENABLE0);
  assign rd_st_idx  = out_idx(i_araddr, `EVR_OFF_STATUS0);
  assign rd_irqstat = off_is(i_araddr, `EVR_OFF_IRQSTAT);
  assign rd_hit     = off_is(i_araddr, `EVR_OFF_POLARITY) |
                      off_is(i_araddr, `EVR_OFF_MODE) |
                      off_is(i_araddr, `EVR_OFF_GMASK) |
                      off_is(i_araddr, `EVR_OFF_CLEAR) |
                      off_is(i_araddr, `EVR_OFF_PRESENT) |
                      off_is(i_araddr, `EVR_OFF_IRQMASK) |
                      rd_irqstat |
                      in_bank(i_araddr, `EVR_OFF_ENABLE0) |
                      in_bank(i_araddr, `EVR_OFF_STATUS0);

  always_comb
  begin
    rd_word = '0;
    if (off_is(i_araddr, `EVR_OFF_POLARITY))
      rd_word = polarity;
    else if (off_is(i_araddr, `EVR_OFF_MODE))
      rd_word = mode;
    else if (off_is(i_araddr, `EVR_OFF_GMASK))
      rd_word = gmask;
    else if (off_is(i_araddr, `EVR_OFF_PRESENT))
      rd_word = present;
    else if (rd_irqstat)
      rd_word = {27'h0000000, irq_stat};
    else if (off_is(i_araddr, `EVR_OFF_IRQMASK))
      rd_word = {27'h0000000, irq_mask};
    else if (in_bank(i_araddr, `EVR_OFF_ENABLE0))
      rd_word = enable[rd_en_idx];
    else if (in_bank(i_araddr, `EVR_OFF_STATUS0))
      rd_word = routed[rd_st_idx];
  end

  // Sticky status, set wins over read clear
  assign next_irq_stat = (irq_stat & ~((ar_take & rd_irqstat) ?
                         {`EVR_N_OUT{1'b1}} : '0)) | out_rise;

  // Bus flops
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr   <= '0;
      w_data    <= '0;
      w_strb    <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `EVR_RESP_OKAY;
    end
    else
    begin
      aw_got    <= next_aw_got;
      w_got     <= next_w_got;
      o_awready <= ~next_aw_got & ~next_bvalid;
      o_wready  <= ~next_w_got & ~next_bvalid;
      o_bvalid  <= next_bvalid;
      if (aw_take)
        aw_addr <= i_awaddr;
      if (w_take)
      begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write)
        o_bresp <= wr_hit ? `EVR_RESP_OKAY : `EVR_RESP_SLVERR;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= `EVR_RESP_OKAY;
    end
    else
    begin
      o_arready <= ~(o_rvalid & ~i_rready) & ~ar_take;
      if (ar_take)
      begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_hit ? rd_word : '0;
        o_rresp  <= rd_hit ? `EVR_RESP_OKAY : `EVR_RESP_SLVERR;
      end
      else if (i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      polarity <= `EVR_RST_POLARITY;
      mode     <= `EVR_RST_MODE;
      gmask    <= `EVR_RST_GMASK;
      irq_mask <= `EVR_RST_IRQMASK;
    end
    else if (do_write)
    begin
      if (off_is(aw_addr, `EVR_OFF_POLARITY))
        polarity <= merge(polarity, w_data, w_strb);
      if (off_is(aw_addr, `EVR_OFF_MODE))
        mode <= merge(mode, w_data, w_strb);
      if (off_is(aw_addr, `EVR_OFF_GMASK))
        gmask <= merge(gmask, w_data, w_strb);
      if (off_is(aw_addr, `EVR_OFF_IRQMASK) && w_strb[0])
        irq_mask <= w_data[`EVR_N_OUT-1:0];
    end
  end

  generate
    for (g = 0; g < `EVR_N_OUT; g++)
    begin : g_enable
      always_ff @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          enable[g] <= `EVR_RST_ENABLE;
        else if (do_write && in_bank(aw_addr, `EVR_OFF_ENABLE0) &&
                 wr_en_idx == 3'(g))
          enable[g] <= merge(enable[g], w_data, w_strb);
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_q       <= '0;
      o_event_int <= '0;
      o_wakeup    <= 1'b0;
      irq_stat    <= '0;
      o_irq       <= 1'b0;
    end
    else
    begin
      out_q       <= out_now;
      o_event_int <= out_now[`EVR_N_IRQ-1:0];
      o_wakeup    <= out_now[`EVR_WAKE_IDX];
      irq_stat    <= next_irq_stat;
      o_irq       <= |(next_irq_stat & irq_mask);
    end
  end

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot};

endmodule : evr_router
